// file: core/gpio_dbus_map.svh
// Register offsets, reset values and field layout for the dual-port GPIO block
`ifndef GPIO_DBUS_MAP_SVH
`define GPIO_DBUS_MAP_SVH
// Printed offsets are register indices; byte address is four times the index
`define IDX_LOW_DATA 3'h0
`define IDX_HIGH_DATA 3'h1
`define IDX_LOW_DIR 3'h2
`define IDX_HIGH_DIR 3'h4
`define IDX_HIGH_FUNC 3'h5
`define RST_LOW_LATCH 8'h00
`define RST_HIGH_LATCH 8'h00
`define RST_LOW_DIR 8'h00
`define RST_HIGH_DIR 8'h00
`define RST_HIGH_FUNC 8'h00
`define ADDR_LSB 2
`define ADDR_MSB 4
`endif

// file: core/gpio_dbus_pkg.sv
// Types shared by the dual-port GPIO block
package gpio_dbus_pkg;
  typedef enum logic [1:0] {
    PIN_INPUT,
    PIN_OUTPUT,
    PIN_DATA_BUS,
    PIN_FORBIDDEN
  } pin_mode_t;
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
  } low_port_t;
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] func;
  } high_port_t;
  typedef struct packed {
    logic [15:0] wdata;
    logic        drive;
  } bus_req_t;
endpackage

// file: core/gpio_dbus.sv
// Dual 8-bit GPIO ports shared with the external data bus, APB register slave
//
// Contract
// R1: Each low port pin is an input when its direction bit is 0 and an output when it is 1.
// R2: Reset clears the low port direction register so all low pins start as inputs.
// R3: An external memory access turns the low port into data bits 0-7 and clears its direction.
// R4: In the external-ROM variant the low port is always data bits 0-7.
// R5: Software writes the low port direction register only as a whole word, never by read-modify-write.
// R6: Each high pin mode decodes from direction and function: input, output, data bus, forbidden.
// R7: Reset clears the high port latch, direction and function registers to input mode.
// R8: External-ROM variant with strap low at reset: high port is data bits 8-15.
// R9: External-ROM variant with strap high at reset: high port is an ordinary I/O port.
// R10: External-ROM variant with strap low: all high port function bits read as fixed 1 (the code reads them back as 0; only the pin mode decode sees 1).
// R11: While function bits are fixed at 1, software never writes 1 to a high direction bit.
// R12: External-ROM variant with strap high: data bus function leaves high pins floating.
// R13: Data writes load the latch, outputs drive it, reads return pin levels on inputs.
`timescale 1ns/1ps
`include "gpio_dbus_map.svh"
module gpio_dbus #(
  parameter bit EXT_ROM = 1'b0
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Bus controller
  input wire logic EXT_ACCESS,
  input wire logic EXT_DRIVE,
  input wire logic [15:0] EXT_WDATA,
  output logic [15:0] EXT_RDATA,
  // Strap
  input wire logic BUS_WIDTH_STRAP_PIN,
  // Pins
  input wire logic [7:0] LOW_PIN_I,
  output logic [7:0] LOW_PIN_O,
  output logic [7:0] LOW_PIN_OE_N,
  input wire logic [7:0] HIGH_PIN_I,
  output logic [7:0] HIGH_PIN_O,
  output logic [7:0] HIGH_PIN_OE_N
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] low_s1_ff, low_s2_ff, high_s1_ff, high_s2_ff;
  logic [15:0] ext_s1_ff, ext_s2_ff;
  logic strap_s1_ff, strap_s2_ff;
  logic [2:0] nxt_strap_cnt;
  logic [2:0] strap_cnt_ff;
  logic strap_low_ff, nxt_strap_low;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      low_s1_ff <= 8'h00;
      low_s2_ff <= 8'h00;
      high_s1_ff <= 8'h00;
      high_s2_ff <= 8'h00;
      ext_s1_ff <= 16'h0000;
      ext_s2_ff <= 16'h0000;
      strap_s1_ff <= 1'b0;
      strap_s2_ff <= 1'b0;
    end else if (CE) begin
      low_s1_ff <= LOW_PIN_I;
      low_s2_ff <= low_s1_ff;
      high_s1_ff <= HIGH_PIN_I;
      high_s2_ff <= high_s1_ff;
      ext_s1_ff <= {HIGH_PIN_I, LOW_PIN_I};
      ext_s2_ff <= ext_s1_ff;
      strap_s1_ff <= BUS_WIDTH_STRAP_PIN;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  // Strap is caught once the synchroniser has filled, then held until reset
  always_comb begin
    nxt_strap_cnt = strap_cnt_ff;
    nxt_strap_low = strap_low_ff;
    if (strap_cnt_ff != 3'h3) begin
      nxt_strap_cnt = strap_cnt_ff + 3'h1;
      if (strap_cnt_ff == 3'h2) begin
        nxt_strap_low = ~strap_s2_ff;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      strap_cnt_ff <= 3'h0;
      strap_low_ff <= 1'b0;
    end else if (CE) begin
      strap_cnt_ff <= nxt_strap_cnt;
      strap_low_ff <= nxt_strap_low;
    end
  end

  logic strap_done;
  logic rom16;
  logic rom8;
  assign strap_done = (strap_cnt_ff == 3'h3);
  assign rom16 = EXT_ROM && strap_done && strap_low_ff;
  assign rom8 = EXT_ROM && strap_done && !strap_low_ff;

  // ----------------------------------------------------------------
  // APB decode and register file
  // ----------------------------------------------------------------
  gpio_dbus_pkg::low_port_t low_ff, nxt_low;
  gpio_dbus_pkg::high_port_t high_ff, nxt_high;
  logic [2:0] idx;
  logic wr_en;
  logic mapped;
  logic [7:0] func_eff;

  assign idx = PADDR[`ADDR_MSB:`ADDR_LSB];
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign mapped = (PADDR[31:`ADDR_MSB+1] == 27'h0) && (PADDR[1:0] == 2'h0) &&
                  (idx == `IDX_LOW_DATA || idx == `IDX_HIGH_DATA || idx == `IDX_LOW_DIR ||
                   idx == `IDX_HIGH_DIR || idx == `IDX_HIGH_FUNC);
  // Function bits forced high while the wide-bus strap is active
  assign func_eff = rom16 ? 8'hFF : high_ff.func; // R10

  // Direction registers take whole-byte writes only; no per-bit update path exists
  always_comb begin
    nxt_low = low_ff;
    nxt_high = high_ff;
    if (wr_en && mapped) begin
      case (idx)
        `IDX_LOW_DATA: nxt_low.latch = PWDATA[7:0]; // R13
        `IDX_HIGH_DATA: nxt_high.latch = PWDATA[7:0]; // R13
        `IDX_LOW_DIR: nxt_low.dir = PWDATA[7:0]; // R1 R5
        `IDX_HIGH_DIR: nxt_high.dir = PWDATA[7:0];
        `IDX_HIGH_FUNC: nxt_high.func = PWDATA[7:0];
        default: nxt_low = low_ff;
      endcase
    end
    // Bus access wins over a simultaneous software low port direction write
    if (EXT_ACCESS || EXT_ROM) begin
      nxt_low.dir = 8'h00; // R3
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      low_ff <= '{latch: `RST_LOW_LATCH, dir: `RST_LOW_DIR}; // R2
      high_ff <= '{latch: `RST_HIGH_LATCH, dir: `RST_HIGH_DIR, func: `RST_HIGH_FUNC}; // R7
    end else if (CE) begin
      low_ff <= nxt_low;
      high_ff <= nxt_high;
    end
  end

  // ----------------------------------------------------------------
  // Pin mode decode
  // ----------------------------------------------------------------
  gpio_dbus_pkg::pin_mode_t high_mode [8];
  logic low_bus;
  assign low_bus = EXT_ACCESS || EXT_ROM; // R3 R4

  logic [7:0] low_o, low_oe_n, high_o, high_oe_n, low_rd, high_rd;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      always_comb begin
        case ({high_ff.dir[g], func_eff[g]})
          2'b00: high_mode[g] = gpio_dbus_pkg::PIN_INPUT; // R6
          2'b10: high_mode[g] = gpio_dbus_pkg::PIN_OUTPUT;
          2'b01: high_mode[g] = gpio_dbus_pkg::PIN_DATA_BUS;
          default: high_mode[g] = gpio_dbus_pkg::PIN_FORBIDDEN;
        endcase
      end
      always_comb begin
        if (low_bus) begin
          low_o[g] = EXT_WDATA[g];
          low_oe_n[g] = ~EXT_DRIVE;
        end else begin
          low_o[g] = low_ff.latch[g];
          low_oe_n[g] = ~low_ff.dir[g]; // R1 R13
        end
        low_rd[g] = low_ff.dir[g] ? low_ff.latch[g] : low_s2_ff[g]; // R13
      end
      always_comb begin
        high_o[g] = high_ff.latch[g];
        high_oe_n[g] = 1'b1;
        high_rd[g] = high_s2_ff[g];
        case (high_mode[g])
          gpio_dbus_pkg::PIN_OUTPUT: begin
            high_oe_n[g] = 1'b0; // R9 R13
            high_rd[g] = high_ff.latch[g];
          end
          gpio_dbus_pkg::PIN_DATA_BUS: begin
            // Narrow-bus part floats the pins instead of bussing them
            high_o[g] = EXT_WDATA[8+g];
            high_oe_n[g] = (rom8 || !EXT_DRIVE) ? 1'b1 : 1'b0; // R8 R12
          end
          // Forbidden setting is left floating so a mistake cannot fight the bus
          default: high_oe_n[g] = 1'b1;
        endcase
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered outputs; PREADY and PSLVERR are combinational
  // ----------------------------------------------------------------
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (PSEL && !PENABLE && !PWRITE && mapped) begin
      case (idx)
        `IDX_LOW_DATA: nxt_rdata = {24'h000000, low_rd};
        `IDX_HIGH_DATA: nxt_rdata = {24'h000000, high_rd};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end else if (PSEL && PENABLE) begin
      nxt_rdata = PRDATA;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PRDATA <= 32'h0000_0000;
      LOW_PIN_O <= 8'h00;
      LOW_PIN_OE_N <= 8'hFF;
      HIGH_PIN_O <= 8'h00;
      HIGH_PIN_OE_N <= 8'hFF;
      EXT_RDATA <= 16'h0000;
    end else if (CE) begin
      PRDATA <= nxt_rdata;
      LOW_PIN_O <= low_o;
      LOW_PIN_OE_N <= low_oe_n;
      HIGH_PIN_O <= high_o;
      HIGH_PIN_OE_N <= high_oe_n;
      EXT_RDATA <= ext_s2_ff;
    end
  end

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_bus_access;
    EXT_ACCESS && CE;
  endsequence

  property p_low_dir_clear;
    @(posedge CLK) disable iff (!NRST) s_bus_access |=> (low_ff.dir == 8'h00);
  endproperty
  a_low_dir_clear: assert property (p_low_dir_clear) else $error("low dir not cleared"); // R3

  property p_low_bus_pins;
    @(posedge CLK) disable iff (!NRST)
      (CE && EXT_ACCESS) |=> (LOW_PIN_OE_N == {8{~$past(EXT_DRIVE)}});
  endproperty
  a_low_bus_pins: assert property (p_low_bus_pins) else $error("low pins not on bus"); // R3 R4

  property p_low_out;
    @(posedge CLK) disable iff (!NRST)
      (CE && !low_bus) |=> (LOW_PIN_OE_N == ~$past(low_ff.dir)) &&
                           (LOW_PIN_O == $past(low_ff.latch));
  endproperty
  a_low_out: assert property (p_low_out) else $error("low pin drive wrong"); // R1

  property p_reset_dir;
    @(posedge CLK) $rose(NRST) |-> (low_ff.dir == 8'h00) && (high_ff.func == 8'h00);
  endproperty
  a_reset_dir: assert property (p_reset_dir) else $error("reset state wrong"); // R2 R7

  property p_func_fixed;
    @(posedge CLK) disable iff (!NRST)
      (CE && rom16 && high_ff.dir == 8'h00) |=> (HIGH_PIN_OE_N == {8{~$past(EXT_DRIVE)}});
  endproperty
  a_func_fixed: assert property (p_func_fixed) else $error("function not fixed"); // R10

  property p_forbid_float;
    @(posedge CLK) disable iff (!NRST)
      (CE && (high_ff.dir & func_eff) != 8'h00) |=>
      ((HIGH_PIN_OE_N & $past(high_ff.dir & func_eff)) == $past(high_ff.dir & func_eff));
  endproperty
  a_forbid_float: assert property (p_forbid_float) else $error("forbidden pin driven"); // R6

  property p_rom8_float;
    @(posedge CLK) disable iff (!NRST)
      (CE && rom8 && high_ff.dir == 8'h00 && high_ff.func == 8'hFF) |=> (HIGH_PIN_OE_N == 8'hFF);
  endproperty
  a_rom8_float: assert property (p_rom8_float) else $error("narrow bus pins driven"); // R12

  property p_data_write;
    @(posedge CLK) disable iff (!NRST)
      (CE && wr_en && idx == `IDX_HIGH_DATA && PADDR[1:0] == 2'h0 && PADDR[31:5] == 27'h0)
      |=> (high_ff.latch == $past(PWDATA[7:0]));
  endproperty
  a_data_write: assert property (p_data_write) else $error("latch not written"); // R13

endmodule

// file: tb/ext_mem_model.sv
// Behavioural external memory and board wiring on the shared data pins
`timescale 1ns/1ps
module ext_mem_model (
  // Bus control from the device side
  input wire logic ext_on,
  input wire logic dev_drive,
  input wire logic [15:0] rd_word,
  input wire logic [15:0] board,
  // Device pins
  input wire logic [15:0] dev_o,
  input wire logic [15:0] dev_oe_n,
  output logic [15:0] pin
);
  logic mem_on;
  // Memory answers a read only while the device leaves the bus free
  assign mem_on = ext_on & ~dev_drive;
  always_comb begin
    for (int b = 0; b < 16; b++) begin
      if (!dev_oe_n[b]) begin
        pin[b] = dev_o[b];
      end else if (mem_on) begin
        pin[b] = rd_word[b];
      end else begin
        pin[b] = board[b];
      end
    end
  end
endmodule

// file: tb/dual_port_gpio_data_bus_mux_tb.sv
// Self-checking bench for the dual-port GPIO block
`timescale 1ns/1ps
`include "gpio_dbus_map.svh"
module dual_port_gpio_data_bus_mux_tb;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, ext_acc, ext_drv, strap, err;
  logic [31:0] paddr, pwdata, prdata, rd, seed;
  logic [15:0] ext_wd, ext_rd, mem_word, board, pins;
  logic [7:0] lo_o, lo_oe_n, hi_o, hi_oe_n, dir, dat, hd, fn, hl, bus;
  logic [7:0] r_lo_o, r_lo_oe_n, r_hi_o, r_hi_oe_n;
  int error_cnt;
  int checks;
  gpio_dbus #(.EXT_ROM(1'b0)) dut (.CLK(clk), .NRST(nrst), .CE(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EXT_ACCESS(ext_acc), .EXT_DRIVE(ext_drv),
    .EXT_WDATA(ext_wd), .EXT_RDATA(ext_rd), .BUS_WIDTH_STRAP_PIN(strap),
    .LOW_PIN_I(pins[7:0]), .LOW_PIN_O(lo_o), .LOW_PIN_OE_N(lo_oe_n),
    .HIGH_PIN_I(pins[15:8]), .HIGH_PIN_O(hi_o), .HIGH_PIN_OE_N(hi_oe_n));
  ext_mem_model mem (.ext_on(ext_acc), .dev_drive(ext_drv), .rd_word(mem_word),
    .board(board), .dev_o({hi_o, lo_o}), .dev_oe_n({hi_oe_n, lo_oe_n}), .pin(pins));
  // External-ROM variant watched alongside on the same bus; its pins stay off the board
  gpio_dbus #(.EXT_ROM(1'b1)) dut_rom (.CLK(clk), .NRST(nrst), .CE(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(),
    .PREADY(), .PSLVERR(), .EXT_ACCESS(ext_acc), .EXT_DRIVE(ext_drv),
    .EXT_WDATA(ext_wd), .EXT_RDATA(), .BUS_WIDTH_STRAP_PIN(strap),
    .LOW_PIN_I(pins[7:0]), .LOW_PIN_O(r_lo_o), .LOW_PIN_OE_N(r_lo_oe_n),
    .HIGH_PIN_I(pins[15:8]), .HIGH_PIN_O(r_hi_o), .HIGH_PIN_OE_N(r_hi_oe_n));
  // --------------------------------
  // Helpers
  // --------------------------------
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [31:0] ad(input logic [2:0] idx);
    return {27'h0000000, idx, 2'b00};
  endfunction
  // Driven pins read back the latch, all others the level on the board
  function automatic logic [31:0] rdx(input logic [7:0] lat, drv, pin);
    return {24'h000000, (lat & drv) | (pin & ~drv)};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Idle edge first so a strobe is never lowered and raised in one step
  task automatic apb(input logic wr, input logic [31:0] a, d);
    int n;
    logic rdy;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is taken at the rising edge, before the slave's registers move on
    do begin
      @(posedge clk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
      n++;
      if (n > 20) begin
        error_cnt++;
        summarize();
      end
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // --------------------------------
  // Stimulus
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {nrst, psel, penable, pwrite, ext_acc, ext_drv, strap} = 7'h01;
    {paddr, pwdata, ext_wd, mem_word, board} = '0;
    seed = 32'h00000062;
    error_cnt = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    settle(1);
    chk("low_oe_n", 32'h000000FF, {24'h000000, lo_oe_n});
    chk("high_oe_n", 32'h000000FF, {24'h000000, hi_oe_n});
    apb(1'b1, ad(`IDX_HIGH_DIR), 32'h000000FF);
    settle(2);
    chk("high_o", 32'h00000000, {24'h000000, hi_o});
    for (int i = 0; i < 8; i++) begin
      {dir, dat, hd, fn, hl} = {rnd(), rnd(), rnd(), rnd(), rnd()};
      // First pass forces all four direction/function pairs
      if (i == 0) {hd, fn} = 16'h5A3C;
      // Last pass puts every high pin on the bus for the access that follows
      if (i == 7) {hd, fn} = 16'h00FF;
      board <= {rnd(), rnd()};
      apb(1'b1, ad(`IDX_LOW_DIR), {24'h000000, dir});
      apb(1'b1, ad(`IDX_LOW_DATA), {24'h000000, dat});
      apb(1'b1, ad(`IDX_HIGH_DIR), {24'h000000, hd});
      apb(1'b1, ad(`IDX_HIGH_FUNC), {24'h000000, fn});
      apb(1'b1, ad(`IDX_HIGH_DATA), {24'h000000, hl});
      settle(4);
      chk("low_oe_n", {24'h000000, ~dir}, {24'h000000, lo_oe_n});
      chk("low_o", {24'h000000, dat & dir}, {24'h000000, lo_o & dir});
      chk("high_oe_n", {24'h000000, ~(hd & ~fn)}, {24'h000000, hi_oe_n});
      chk("rom_low_oe_n", 32'h000000FF, {24'h000000, r_lo_oe_n});
      chk("rom_high_oe_n", {24'h000000, ~(hd & ~fn)}, {24'h000000, r_hi_oe_n});
      apb(1'b0, ad(`IDX_LOW_DATA), 32'h00000000);
      chk("low_rd", rdx(dat, dir, board[7:0]), rd);
      apb(1'b0, ad(`IDX_HIGH_DATA), 32'h00000000);
      chk("high_rd", rdx(hl, hd & ~fn, board[15:8]), rd);
      apb(1'b0, ad(`IDX_LOW_DIR), 32'h00000000);
      chk("dir_rd", 32'h00000000, rd);
    end
    bus = fn & ~hd;
    @(posedge clk);
    ext_wd <= {rnd(), rnd()};
    ext_drv <= 1'b1;
    ext_acc <= 1'b1;
    settle(2);
    chk("low_oe_n", 32'h00000000, {24'h000000, lo_oe_n});
    chk("low_o", {24'h000000, ext_wd[7:0]}, {24'h000000, lo_o});
    chk("high_oe_n", {24'h000000, ~((hd & ~fn) | bus)}, {24'h000000, hi_oe_n});
    chk("high_o", {24'h000000, ext_wd[15:8] & bus}, {24'h000000, hi_o & bus});
    chk("rom_low_oe_n", 32'h00000000, {24'h000000, r_lo_oe_n});
    chk("rom_low_o", {24'h000000, ext_wd[7:0]}, {24'h000000, r_lo_o});
    chk("rom_high_oe_n", {24'h000000, ~(hd & ~fn)}, {24'h000000, r_hi_oe_n});
    @(posedge clk);
    ext_drv <= 1'b0;
    mem_word <= {rnd(), rnd()};
    settle(6);
    chk("ext_rd_lo", {24'h000000, mem_word[7:0]}, {24'h000000, ext_rd[7:0]});
    chk("ext_rd_hi", {24'h000000, mem_word[15:8] & bus}, {24'h000000, ext_rd[15:8] & bus});
    @(posedge clk);
    ext_acc <= 1'b0;
    settle(2);
    chk("low_oe_n", 32'h000000FF, {24'h000000, lo_oe_n});
    apb(1'b1, 32'h0000000C, 32'h000000FF);
    chk("slverr", 32'h00000001, {31'h00000000, err});
    apb(1'b0, 32'h00000001, 32'h00000000);
    chk("slverr", 32'h00000001, {31'h00000000, err});
    chk("bad_rd", 32'h00000000, rd);
    @(posedge clk);
    nrst <= 1'b0;
    settle(1);
    chk("high_oe_n", 32'h000000FF, {24'h000000, hi_oe_n});
    chk("low_oe_n", 32'h000000FF, {24'h000000, lo_oe_n});
    // Wide-bus strap: captured only after reset, so change it while reset is held
    @(posedge clk);
    strap <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    settle(5);
    chk("rom_high_oe_n", 32'h000000FF, {24'h000000, r_hi_oe_n});
    apb(1'b1, ad(`IDX_HIGH_FUNC), 32'h00000000);
    apb(1'b1, ad(`IDX_HIGH_DIR), 32'h00000000);
    @(posedge clk);
    ext_acc <= 1'b1;
    ext_drv <= 1'b1;
    settle(2);
    chk("rom_high_oe_n", 32'h00000000, {24'h000000, r_hi_oe_n});
    chk("rom_high_o", {24'h000000, ext_wd[15:8]}, {24'h000000, r_hi_o});
    chk("high_oe_n", 32'h000000FF, {24'h000000, hi_oe_n});
    @(posedge clk);
    ext_acc <= 1'b0;
    ext_drv <= 1'b0;
    settle(1);
    summarize();
  end
endmodule
